// ===== design/mic_pkg.sv
// Constants, types and register map of the interrupt controller.
// Assumes one core clock, synchronous active-high reset, byte-wide register port.
//
// Contract
// - Four maskable sources plus one non-maskable source; non-maskable has top priority.
// - Accepted request loads its fixed vector: FFC, FF6, FF4, FF2, FF0.
// - Non-maskable preempts any maskable routine, never its own; maskable never preempts maskable routine.
// - Pending maskable requests served by fixed priority, source 1 highest.
// - Global enable gates maskable sources and gates wake-up for every source.
// - With global enable low, non-maskable still serviced but cannot wake.
// - Non-maskable request held in flip-flop cleared when its routine starts.
// - Source 1 level sensitive when mode bit set, falling edge otherwise.
// - Source 2 always edge; rising edge when polarity bit set, else falling.
// - Sources 3 and 4 are level sensitive only.
// - Edge latch sets on edge, clears at routine start; keeps only one.
// - Level requests not stored; line must be low at instruction end.
// - Lines checked at each instruction end; pending request replaces next instruction.
// - Separate carry/zero sets per mode, swapped automatically on entry.
// - Program counter pushed on hardware stack before the vector is loaded.
// - Entry inhibits maskable requests, leaves non-maskable live, clears entry latch.
// - Return instruction restores previous flag set and pops saved counter.
// - Maskable arrival in first 3 cycles of option clear skips flag swap.
// - Shared sources keep per-event flags that software polls.
// - Option register write-only, cleared to zero by reset.
// - Option bit 6 source 1 mode, bit 5 polarity, bit 4 enable.

package mic_pkg;

	// Register map
	localparam logic [7:0] OPT_ADDR      = 8'hC8;
	localparam logic [7:0] STATUS_ADDR   = 8'hF8;
	localparam logic [7:0] EVENT_ADDR    = 8'hF9;
	localparam logic [7:0] OPT_RESET     = 8'h00;

	// Option register fields
	localparam int OPT_LES_BIT = 6;
	localparam int OPT_ESB_BIT = 5;
	localparam int OPT_GEN_BIT = 4;

	// Vector addresses, low byte of each pair
	localparam logic [11:0] VEC_NMI  = 12'hFFC;
	localparam logic [11:0] VEC_SRC1 = 12'hFF6;
	localparam logic [11:0] VEC_SRC2 = 12'hFF4;
	localparam logic [11:0] VEC_SRC3 = 12'hFF2;
	localparam logic [11:0] VEC_SRC4 = 12'hFF0;

	// Execution mode, also names the active flag set
	typedef enum logic [1:0] {
		MIC_NORMAL,
		MIC_MASKABLE,
		MIC_NONMASK
	} mic_mode_e;

	// Stored option bits
	typedef struct packed {
		logic src1_level_select;
		logic src2_edge_polarity;
		logic gen;
	} mic_opt_s;

	// Carry and zero pair
	typedef struct packed {
		logic carry;
		logic zero;
	} mic_flags_s;

endpackage : mic_pkg

// ===== design/mic_irq_ctrl.sv
// Interrupt controller top: request capture, arbitration, entry/return sequencing.
// Assumes core pulses instr_end at each instruction boundary and return_from_irq_instr at return;
// pins are asynchronous, peripheral event lines share mclk.
`timescale 1ns/1ps
`default_nettype none

module mic_irq_ctrl #(
	parameter int N_EV2 = 2,
	parameter int N_EV3 = 2,
	parameter int N_EV4 = 2
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	// Register port
	input  wire logic [7:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [7:0]              reg_rdata,
	// Request sources
	input  wire logic                    nmi_pin_n,
	input  wire logic                    src1_pin,
	input  wire logic                    src2_pin,
	input  wire logic [N_EV2-1:0]        src2_events,
	input  wire logic [N_EV3-1:0]        src3_events,
	input  wire logic [N_EV4-1:0]        src4_events,
	// Core side
	input  wire logic                    instr_end,
	input  wire logic                    return_from_irq_instr,
	input  wire logic                    core_asleep,
	input  wire logic                    opt_clear_window,
	input  wire logic [11:0]             core_pc,
	input  wire logic                    flag_we,
	input  wire mic_pkg::mic_flags_s     flag_wdata,
	output mic_pkg::mic_flags_s          flag_active,
	output logic                         irq_enter,
	output logic                         stack_push,
	output logic      [11:0]             stack_push_pc,
	output logic                         stack_pop,
	output logic                         vec_load,
	output logic      [11:0]             vec_addr,
	output logic                         core_wake,
	output mic_pkg::mic_mode_e           irq_mode
);

	// Synchroniser stages for the three pins: [0] nmi, [1] src1, [2] src2
	logic [2:0]               pin_meta_r;
	logic [2:0]               pin_sync_r;
	logic [2:0]               pin_prev_r;

	// Option register and controller state
	mic_pkg::mic_opt_s        opt_r;
	mic_pkg::mic_mode_e       mode_r;
	mic_pkg::mic_mode_e       prev_mode_r;
	mic_pkg::mic_mode_e       fset_r;
	mic_pkg::mic_mode_e       prev_fset_r;
	mic_pkg::mic_flags_s      flags_norm_r;
	mic_pkg::mic_flags_s      flags_mask_r;
	mic_pkg::mic_flags_s      flags_nmi_r;
	logic                     nmi_latch_r;
	logic                     src1_latch_r;
	logic                     src2_latch_r;
	logic                     anomaly_r;
	logic                     push_r;
	logic [11:0]              push_pc_r;
	logic                     load_r;
	logic [11:0]              vec_r;
	logic                     enter_r;
	logic                     pop_r;
	logic [7:0]               rdata_r;

	// Decoded combinational terms, plus the registered source 2 line history
	logic                     nmi_fall;
	logic                     src1_fall;
	logic                     src2_edge;
	logic                     src1_level_req;
	logic                     src2_line;
	logic                     src3_line_n;
	logic                     src4_line_n;
	logic [4:1]               mask_req;
	logic                     mask_any;
	logic                     take_nmi;
	logic                     take_mask;
	logic [4:1]               grant;
	logic [11:0]              vec_nxt;
	logic                     opt_wr;
	logic                     src2_line_prev_r;

	// Two flops before any logic reads a pin.
	// Pins run free of mclk, so the first stage may go metastable;
	// only the second stage and the edge history feed logic.
	// Reset loads the idle-high level, so no false edge follows reset
	// as long as the pins themselves rest high.
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_meta_r <= 3'h7;
			pin_sync_r <= 3'h7;
			pin_prev_r <= 3'h7;
		end else begin
			pin_meta_r <= {src2_pin, src1_pin, nmi_pin_n};
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// Shared sources: any event pulls the request line; peripherals keep their own flags
	assign src2_line   = pin_sync_r[2] ^ (|src2_events);
	assign src3_line_n = ~(|src3_events);
	assign src4_line_n = ~(|src4_events);

	// Edge detection on synchronised lines
	assign nmi_fall  = pin_prev_r[0] & ~pin_sync_r[0];
	assign src1_fall = ~opt_r.src1_level_select & pin_prev_r[1] & ~pin_sync_r[1];
	assign src2_edge = opt_r.src2_edge_polarity ? (~src2_line_prev_r & src2_line)
	                             : (src2_line_prev_r & ~src2_line);

	// Previous value of the merged source 2 line.
	// Kept after the merge, so a peripheral event and a pin change
	// in one cycle cancel rather than give two edges.
	always_ff @(posedge mclk) begin
		if (rst) begin
			src2_line_prev_r <= 1'b1;
		end else begin
			src2_line_prev_r <= src2_line;
		end
	end

	// Level requests are read live, never stored
	assign src1_level_req = opt_r.src1_level_select & ~pin_sync_r[1];

	// Maskable requests, enable-gated; 3 and 4 have no edge option
	assign mask_req[1] = opt_r.gen & (src1_latch_r | src1_level_req);
	assign mask_req[2] = opt_r.gen & src2_latch_r;
	assign mask_req[3] = opt_r.gen & ~src3_line_n;
	assign mask_req[4] = opt_r.gen & ~src4_line_n;
	assign mask_any    = |mask_req;

	// Arbitration at the instruction boundary.
	// Only an instr_end cycle may take a request, so a level source
	// that drops between boundaries is lost by design.
	// NMI wins outright; maskable sources are a plain priority chain,
	// cheaper than a rotating arbiter and never reprogrammable.
	always_comb begin
		take_nmi  = instr_end & nmi_latch_r & (mode_r != mic_pkg::MIC_NONMASK);
		take_mask = instr_end & ~take_nmi & mask_any
		            & (mode_r == mic_pkg::MIC_NORMAL);
		grant     = 4'h0;
		vec_nxt   = mic_pkg::VEC_NMI;
		if (take_mask) begin
			if (mask_req[1]) begin
				grant[1] = 1'b1;
				vec_nxt  = mic_pkg::VEC_SRC1;
			end else if (mask_req[2]) begin
				grant[2] = 1'b1;
				vec_nxt  = mic_pkg::VEC_SRC2;
			end else if (mask_req[3]) begin
				grant[3] = 1'b1;
				vec_nxt  = mic_pkg::VEC_SRC3;
			end else begin
				grant[4] = 1'b1;
				vec_nxt  = mic_pkg::VEC_SRC4;
			end
		end
	end

	// Option register: only three bits stored, the rest dropped
	assign opt_wr = reg_wr & (reg_addr == mic_pkg::OPT_ADDR);

	always_ff @(posedge mclk) begin
		if (rst) begin
			opt_r <= mic_pkg::OPT_RESET[6:4];
		end else if (opt_wr) begin
			opt_r.src1_level_select <= reg_wdata[mic_pkg::OPT_LES_BIT];
			opt_r.src2_edge_polarity <= reg_wdata[mic_pkg::OPT_ESB_BIT];
			opt_r.gen <= reg_wdata[mic_pkg::OPT_GEN_BIT];
		end
	end

	// Non-maskable latch; a new edge in the clearing cycle wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			nmi_latch_r <= 1'b0;
		end else if (nmi_fall) begin
			nmi_latch_r <= 1'b1;
		end else if (take_nmi) begin
			nmi_latch_r <= 1'b0;
		end
	end

	// Edge latches hold one request until their routine starts.
	// A second edge during the routine folds into the same bit;
	// an edge in the grant cycle itself keeps the latch set, so it
	// is served once more after return rather than lost.
	always_ff @(posedge mclk) begin
		if (rst) begin
			src1_latch_r <= 1'b0;
			src2_latch_r <= 1'b0;
		end else begin
			if (src1_fall) begin
				src1_latch_r <= 1'b1;
			end else if (grant[1] | opt_r.src1_level_select) begin
				src1_latch_r <= 1'b0;
			end
			if (src2_edge) begin
				src2_latch_r <= 1'b1;
			end else if (grant[2]) begin
				src2_latch_r <= 1'b0;
			end
		end
	end

	// Request arriving while the core clears the option register.
	// This reproduces a known flaw on purpose: the next maskable take
	// switches mode but leaves the normal flag bank in place.
	// Software that clears the option register with requests live
	// must expect its normal flags to be altered by the routine.
	always_ff @(posedge mclk) begin
		if (rst) begin
			anomaly_r <= 1'b0;
		end else if (opt_clear_window & mask_any & (mode_r == mic_pkg::MIC_NORMAL)) begin
			anomaly_r <= 1'b1;
		end else if (take_mask | take_nmi | ~opt_clear_window & ~mask_any) begin
			anomaly_r <= 1'b0;
		end
	end

	// Execution mode: one level of nesting, NMI over a maskable routine.
	// Only one previous mode is saved; NMI never nests in NMI,
	// so a deeper history is never needed.
	// Entry takes priority over a return in the same cycle.
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_r      <= mic_pkg::MIC_NORMAL;
			prev_mode_r <= mic_pkg::MIC_NORMAL;
		end else if (take_nmi) begin
			prev_mode_r <= mode_r;
			mode_r      <= mic_pkg::MIC_NONMASK;
		end else if (take_mask) begin
			mode_r      <= mic_pkg::MIC_MASKABLE;
		end else if (return_from_irq_instr) begin
			if (mode_r == mic_pkg::MIC_NONMASK) begin
				mode_r <= prev_mode_r;
			end else begin
				mode_r <= mic_pkg::MIC_NORMAL;
			end
			prev_mode_r <= mic_pkg::MIC_NORMAL;
		end
	end

	// Flag set selection, kept apart from mode so the anomaly can show.
	// Its history saves the flag set, not the mode (they differ after the anomaly), so a return
	// always restores the bank that was live before the entry.
	always_ff @(posedge mclk) begin
		if (rst) begin
			fset_r      <= mic_pkg::MIC_NORMAL;
			prev_fset_r <= mic_pkg::MIC_NORMAL;
		end else if (take_nmi) begin
			prev_fset_r <= fset_r;
			fset_r      <= mic_pkg::MIC_NONMASK;
		end else if (take_mask) begin
			if (!anomaly_r) begin
				fset_r <= mic_pkg::MIC_MASKABLE;
			end
		end else if (return_from_irq_instr) begin
			if (fset_r == mic_pkg::MIC_NONMASK) begin
				fset_r <= prev_fset_r;
			end else begin
				fset_r <= mic_pkg::MIC_NORMAL;
			end
			prev_fset_r <= mic_pkg::MIC_NORMAL;
		end
	end

	// Three carry/zero banks; the core writes only the active one
	always_ff @(posedge mclk) begin
		if (rst) begin
			flags_norm_r <= '0;
			flags_mask_r <= '0;
			flags_nmi_r  <= '0;
		end else if (flag_we) begin
			unique case (fset_r)
				mic_pkg::MIC_NORMAL:   flags_norm_r <= flag_wdata;
				mic_pkg::MIC_MASKABLE: flags_mask_r <= flag_wdata;
				mic_pkg::MIC_NONMASK:  flags_nmi_r  <= flag_wdata;
				default:               flags_norm_r <= flag_wdata;
			endcase
		end
	end

	always_comb begin
		unique case (fset_r)
			mic_pkg::MIC_MASKABLE: flag_active = flags_mask_r;
			mic_pkg::MIC_NONMASK:  flag_active = flags_nmi_r;
			default:               flag_active = flags_norm_r;
		endcase
	end

	// Entry sequence: push in the cycle after the take, vector one cycle later.
	// The counter is captured at the take, before the core moves on,
	// so the stack always holds the skipped instruction's address.
	// The vector stays on vec_addr until the next take.
	always_ff @(posedge mclk) begin
		if (rst) begin
			enter_r   <= 1'b0;
			push_r    <= 1'b0;
			push_pc_r <= 12'h000;
			load_r    <= 1'b0;
			vec_r     <= 12'h000;
		end else begin
			enter_r <= take_nmi | take_mask;
			push_r  <= take_nmi | take_mask;
			load_r  <= push_r;
			if (take_nmi | take_mask) begin
				push_pc_r <= core_pc;
				vec_r     <= vec_nxt;
			end
		end
	end

	// Return pops the saved counter
	always_ff @(posedge mclk) begin
		if (rst) begin
			pop_r <= 1'b0;
		end else begin
			pop_r <= return_from_irq_instr & (mode_r != mic_pkg::MIC_NORMAL);
		end
	end

	// Wake needs the global enable even for NMI; mode does not block it.
	// Left combinational so a sleeping core with a stopped boundary
	// pulse still sees the request in the same cycle.
	assign core_wake = core_asleep & opt_r.gen
	                   & (nmi_latch_r | mask_any);

	// Register reads: option is write-only and reads zero.
	// Data stand for one cycle after the strobe and return to zero,
	// so a stale value is never mistaken for a fresh read.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				mic_pkg::STATUS_ADDR: rdata_r <= {fset_r, mode_r, nmi_latch_r,
				                                  src1_latch_r, src2_latch_r, opt_r.gen};
				mic_pkg::EVENT_ADDR:  rdata_r <= {4'h0, ~src4_line_n, ~src3_line_n,
				                                  |src2_events, nmi_latch_r};
				default:              rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata     = rdata_r;
	assign irq_enter     = enter_r;
	assign stack_push    = push_r;
	assign stack_push_pc = push_pc_r;
	assign stack_pop     = pop_r;
	assign vec_load      = load_r;
	assign vec_addr      = vec_r;
	assign irq_mode      = mode_r;

endmodule : mic_irq_ctrl

`default_nettype wire

// ===== verification/mic_irq_sva.sv
// Port assertions for the interrupt controller.
// Assumes binding onto mic_irq_ctrl; the enable bit is shadowed from writes.
`timescale 1ns/1ps
`default_nettype none
module mic_irq_sva #(
	parameter int N_EV2 = 2,
	parameter int N_EV3 = 2,
	parameter int N_EV4 = 2
) (
	input wire logic                mclk,
	input wire logic                rst,
	input wire logic [7:0]          reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [7:0]          reg_rdata,
	input wire logic                nmi_pin_n,
	input wire logic                src1_pin,
	input wire logic                src2_pin,
	input wire logic [N_EV2-1:0]    src2_events,
	input wire logic [N_EV3-1:0]    src3_events,
	input wire logic [N_EV4-1:0]    src4_events,
	input wire logic                instr_end,
	input wire logic                return_from_irq_instr,
	input wire logic                core_asleep,
	input wire logic                opt_clear_window,
	input wire logic [11:0]         core_pc,
	input wire logic                flag_we,
	input wire mic_pkg::mic_flags_s flag_wdata,
	input wire mic_pkg::mic_flags_s flag_active,
	input wire logic                irq_enter,
	input wire logic                stack_push,
	input wire logic [11:0]         stack_push_pc,
	input wire logic                stack_pop,
	input wire logic                vec_load,
	input wire logic [11:0]         vec_addr,
	input wire logic                core_wake,
	input wire mic_pkg::mic_mode_e  irq_mode
);
	logic en_shadow_r;

	// Shadow of the enable bit, same write latency as the option register
	always_ff @(posedge mclk) begin
		if (rst)
			en_shadow_r <= 1'h0;
		else if (reg_wr && reg_addr == mic_pkg::OPT_ADDR)
			en_shadow_r <= reg_wdata[mic_pkg::OPT_GEN_BIT];
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	entry_seq_a : assert property (irq_enter |-> stack_push ##1 vec_load)
		else $error("entry without push and vector load");
	push_pc_a : assert property (stack_push |-> stack_push_pc == $past(core_pc))
		else $error("pushed counter differs from core counter");
	entry_cause_a : assert property (irq_enter |-> $past(instr_end))
		else $error("entry outside an instruction boundary");
	mask_nest_a : assert property (irq_enter && irq_mode == mic_pkg::MIC_MASKABLE
		|-> $past(irq_mode) == mic_pkg::MIC_NORMAL && $past(en_shadow_r))
		else $error("maskable entry while busy or disabled");
	nmi_vec_a : assert property (irq_enter && irq_mode == mic_pkg::MIC_NONMASK
		|=> vec_load && vec_addr == mic_pkg::VEC_NMI)
		else $error("wrong non-maskable vector");
	mask_vec_a : assert property (irq_enter && irq_mode == mic_pkg::MIC_MASKABLE
		|=> vec_addr inside {12'hFF6, 12'hFF4, 12'hFF2, 12'hFF0})
		else $error("maskable vector out of table");
	wake_gate_a : assert property (core_wake |-> core_asleep && en_shadow_r)
		else $error("wake while awake or disabled");
	rdata_idle_a : assert property (!$past(reg_rd) || $past(reg_addr) == mic_pkg::OPT_ADDR
		|-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	pop_cause_a : assert property (stack_pop |-> $past(return_from_irq_instr)
		&& $past(irq_mode) != mic_pkg::MIC_NORMAL)
		else $error("pop without return in a routine");
	mode_step_a : assert property ($changed(irq_mode) |-> irq_enter || stack_pop)
		else $error("mode changed without entry or return");
endmodule : mic_irq_sva

bind mic_irq_ctrl mic_irq_sva #(.N_EV2(N_EV2), .N_EV3(N_EV3), .N_EV4(N_EV4)) u_sva (
	.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nmi_pin_n,
	.src1_pin, .src2_pin, .src2_events, .src3_events, .src4_events, .instr_end,
	.return_from_irq_instr, .core_asleep, .opt_clear_window, .core_pc, .flag_we,
	.flag_wdata, .flag_active, .irq_enter, .stack_push, .stack_push_pc, .stack_pop,
	.vec_load, .vec_addr, .core_wake, .irq_mode);
`default_nettype wire

// ===== verification/mic_core_model.sv
// Core model: instruction boundaries and program counter.
// Assumes an instruction every 2 cycles, 4 when slow; none while asleep.
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        slow,
	input  wire logic        asleep,
	input  wire logic        vec_load,
	input  wire logic [11:0] vec_addr,
	output logic             instr_end,
	output logic      [11:0] core_pc
);
	logic [1:0] cyc_r;

	// Boundary pulses stop in sleep, so no request is taken until asleep drops
	always_ff @(posedge mclk) begin
		if (rst) begin
			cyc_r <= 2'h0;
			instr_end <= 1'h0;
			core_pc <= 12'h000;
		end else begin
			cyc_r <= cyc_r + 2'h1;
			instr_end <= !asleep && (slow ? cyc_r == 2'h3 : cyc_r[0]);
			if (vec_load)
				core_pc <= vec_addr;
			else if (instr_end)
				core_pc <= core_pc + 12'h001;
		end
	end
endmodule : mic_core_model
`default_nettype wire

// ===== verification/mic_irq_ctrl_bench.sv
// Self-checking bench for the interrupt controller.
// Assumes the core model paces instructions; all pins start high, s2 is left low from the polarity test on.
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_bench;
	logic                mclk, rst, reg_wr, reg_rd, nmi_n, s1, s2, ret_p, asleep, clr_win;
	logic                flag_we, slow, instr_end, irq_enter, push, pop, vec_load, wake;
	logic [7:0]          reg_addr, reg_wdata, reg_rdata;
	logic [1:0]          ev2, ev3, ev4, e;
	logic [11:0]         core_pc, push_pc, vec_addr;
	mic_pkg::mic_flags_s flag_wdata, flag_active;
	mic_pkg::mic_mode_e  irq_mode;
	int                  num_errors, samples_checked, k, src;

	mic_irq_ctrl dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_pin_n(nmi_n),
		.src1_pin(s1), .src2_pin(s2), .src2_events(ev2), .src3_events(ev3),
		.src4_events(ev4), .instr_end(instr_end), .return_from_irq_instr(ret_p),
		.core_asleep(asleep), .opt_clear_window(clr_win), .core_pc(core_pc),
		.flag_we(flag_we), .flag_wdata(flag_wdata), .flag_active(flag_active),
		.irq_enter(irq_enter), .stack_push(push), .stack_push_pc(push_pc),
		.stack_pop(pop), .vec_load(vec_load), .vec_addr(vec_addr), .core_wake(wake),
		.irq_mode(irq_mode));
	mic_core_model core (.mclk(mclk), .rst(rst), .slow(slow), .asleep(asleep),
		.vec_load(vec_load), .vec_addr(vec_addr), .instr_end(instr_end), .core_pc(core_pc));

	// Free-running 125 MHz clock
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end

	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : wr

	// Read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		check({4'h0, reg_rdata}, {4'h0, exp});
	endtask : rd

	// Bounded wait for the vector load pulse
	task automatic wait_vec(input logic [11:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (vec_load !== 1'h1 && n < 80);
		if (vec_load !== 1'h1) begin
			num_errors++;
			$display("BAD %0t no entry", $time);
			summarize();
		end
		check(vec_addr, exp);
	endtask : wait_vec

	// Neither entry nor wake may show for cyc cycles
	task automatic no_vec(input int cyc);
		repeat (cyc) begin
			@(posedge mclk);
			#1;
			check({10'h000, vec_load, wake}, 12'h000);
		end
	endtask : no_vec

	task automatic ret_irq;
		@(posedge mclk);
		ret_p <= 1'h1;
		@(posedge mclk);
		ret_p <= 1'h0;
	endtask : ret_irq

	function automatic logic [11:0] exp_vec(input int s);
		case (s)
			1: return mic_pkg::VEC_SRC1;
			2: return mic_pkg::VEC_SRC2;
			3: return mic_pkg::VEC_SRC3;
			default: return mic_pkg::VEC_SRC4;
		endcase
	endfunction : exp_vec

	// Main sequence: reset state, gating, priority, preemption, modes, random sweep
	initial begin
		{rst, nmi_n, s1, s2} = 4'hF;
		{reg_wr, reg_rd, ret_p, asleep, clr_win, flag_we, slow} = 7'h00;
		{reg_addr, reg_wdata, ev2, ev3, ev4} = 22'h000000;
		flag_wdata = 2'h0;
		num_errors = 0;
		samples_checked = 0;
		k = $urandom(7140);
		repeat (8) @(posedge mclk);
		rst <= 1'h0;
		rd(mic_pkg::OPT_ADDR, 8'h00);
		rd(mic_pkg::STATUS_ADDR, 8'h00);
		rd(8'h5A, 8'h00);
		@(posedge mclk);
		ev3 <= 2'h1;
		asleep <= 1'h1;
		nmi_n <= 1'h0;
		no_vec(20);
		asleep <= 1'h0;
		nmi_n <= 1'h1;
		wait_vec(mic_pkg::VEC_NMI);
		ret_irq();
		no_vec(20);
		ev3 <= 2'h0;
		flag_we <= 1'h1;
		flag_wdata <= 2'h3;
		@(posedge mclk);
		flag_we <= 1'h0;
		wr(mic_pkg::OPT_ADDR, 8'h10);
		rd(mic_pkg::STATUS_ADDR, 8'h01);
		asleep <= 1'h1;
		@(posedge mclk);
		ev3 <= 2'h2;
		ev4 <= 2'h1;
		repeat (3) @(posedge mclk);
		#1;
		check({11'h000, wake}, 12'h001);
		asleep <= 1'h0;
		wait_vec(mic_pkg::VEC_SRC3);
		check({10'h000, flag_active}, 12'h000);
		ev3 <= 2'h0;
		ret_irq();
		wait_vec(mic_pkg::VEC_SRC4);
		nmi_n <= 1'h0;
		wait_vec(mic_pkg::VEC_NMI);
		nmi_n <= 1'h1;
		ev4 <= 2'h0;
		ret_irq();
		ret_irq();
		#1;
		check({10'h000, flag_active}, 12'h003);
		asleep <= 1'h1;
		@(posedge mclk);
		clr_win <= 1'h1;
		ev3 <= 2'h3;
		repeat (3) @(posedge mclk);
		clr_win <= 1'h0;
		asleep <= 1'h0;
		wait_vec(mic_pkg::VEC_SRC3);
		check({10'h000, flag_active}, 12'h003);
		ev3 <= 2'h0;
		ret_irq();
		wr(mic_pkg::OPT_ADDR, 8'h30);
		s1 <= 1'h0;
		s2 <= 1'h0;
		wait_vec(mic_pkg::VEC_SRC1);
		s2 <= 1'h1;
		ret_irq();
		wait_vec(mic_pkg::VEC_SRC2);
		ret_irq();
		s1 <= 1'h1;
		s2 <= 1'h0;
		no_vec(20);
		wr(mic_pkg::OPT_ADDR, 8'h50);
		s1 <= 1'h0;
		wait_vec(mic_pkg::VEC_SRC1);
		s1 <= 1'h1;
		ret_irq();
		no_vec(20);
		// Random sources, event masks, pacing and unused option bits
		for (k = 0; k < 12; k++) begin
			src = 2 + int'($urandom % 3);
			e = 2'($urandom_range(3, 1));
			wr(mic_pkg::OPT_ADDR, 8'h30 | (8'($urandom) & 8'h8F));
			slow <= 1'($urandom);
			ev2 <= (src == 2) ? e : 2'h0;
			ev3 <= (src == 3) ? e : 2'h0;
			ev4 <= (src == 4) ? e : 2'h0;
			wait_vec(exp_vec(src));
			{ev2, ev3, ev4} <= 6'h00;
			ret_irq();
		end
		summarize();
	end
endmodule : mic_irq_ctrl_bench
`default_nettype wire
